// ==== hw/accp_pkg.sv ====
// package of constants for the converter control and output port
//
// Operation
// - upper four parallel data bits are always driven, whatever the interface select.
// - busy rises at conversion start, falls after result loads into shift register.
// - output bus enabled only while chip select and read are both low.
// - chip select gates the external serial clock.
// - reset high returns to reset state and aborts any conversion.
// - power-down lets current conversion finish, then refuses new ones.
// - falling edge on convert start enters hold and begins conversion.
// - low-power mode: start still low after acquisition starts conversion at once.
// - normal mode when low-power and fast selects are both low.
// - approximation runs most significant bit first, then busy drops.
package accp_pkg;
	localparam int ACCP_DATA_W = 16;
	localparam int ACCP_CLK_MHZ = 25;
	// acquisition time in ns, then in cycles (least time, rounded up)
	localparam int ACCP_ACQ_NS = 400;
	localparam int ACCP_ACQ_CYC = (ACCP_ACQ_NS * ACCP_CLK_MHZ + 999) / 1000;
	localparam logic [15:0] ACCP_RST_DATA = 16'h0000;
	// reset level of the synchronised pins: start, select and read idle high
	localparam logic [7:0] ACCP_PIN_IDLE = 8'hE0;
	localparam logic [4:0] ACCP_BIT_TOP = 5'h0F;
	localparam logic [7:0] ACCP_ACQ_LAST = 8'(ACCP_ACQ_CYC - 1);
	typedef enum logic [1:0] {
		ACCP_IDLE = 2'b00,
		ACCP_CONV = 2'b01,
		ACCP_LOAD = 2'b10,
		ACCP_ACQ = 2'b11
	} accp_state_t;
endpackage : accp_pkg

// ==== hw/accp_sync.sv ====
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module accp_sync #(
	parameter int W = 1,
	// level both stages take in reset, so an idle pin shows no false edge
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : accp_sync
`default_nettype wire

// ==== hw/accp_top.sv ====
// conversion sequencer and output port control
`timescale 1ns/1ps
`default_nettype none
module accp_top
	import accp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// host control pins
	input wire logic convert_start_n_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic reset_i,
	input wire logic power_down_request_i,
	input wire logic low_power_sel_i,
	input wire logic fast_sel_i,
	input wire logic serial_parallel_select_i,
	input wire logic ext_sclk_i,
	// comparator decision for the bit under trial
	input wire logic comp_i,
	// status and data
	output logic busy_o,
	output logic hold_o,
	output logic [15:0] data_o,
	output logic data_oe_o,
	output logic [15:12] data_hi_oe_o,
	output logic sclk_gated_o
);
	logic [7:0] pins_s;
	logic cnv_n_s;
	logic cs_n_s;
	logic rd_n_s;
	logic reset_s;
	logic pd_s;
	logic lp_s;
	logic fast_s;
	logic sclk_s;
	logic cnv_n_d_r;
	logic start_edge;
	logic lp_mode;
	accp_state_t state_r;
	logic [4:0] bit_r;
	logic [15:0] sar_r;
	logic [15:0] shift_r;
	logic [7:0] acq_r;

	// comparator is clock-synchronous analog logic, not a pin
	accp_sync #(.W(8), .RST_VAL(ACCP_PIN_IDLE)) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.d_i({convert_start_n_i, cs_n_i, rd_n_i, reset_i,
			power_down_request_i, low_power_sel_i, fast_sel_i,
			ext_sclk_i}),
		.q_o(pins_s)
	);
	assign {cnv_n_s, cs_n_s, rd_n_s, reset_s, pd_s, lp_s, fast_s,
		sclk_s} = pins_s;

	assign start_edge = cnv_n_d_r & ~cnv_n_s;
	// normal mode is both selects low; only low-power changes sequencing
	assign lp_mode = lp_s & ~fast_s;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnv_n_d_r <= 1'b1;
		end else begin
			cnv_n_d_r <= cnv_n_s;
		end
	end

	// sequencer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || reset_s) begin
			state_r <= ACCP_IDLE;
			bit_r <= ACCP_BIT_TOP;
			sar_r <= ACCP_RST_DATA;
			acq_r <= 8'h00;
		end else begin
			unique case (state_r)
				ACCP_IDLE: begin
					// power-down blocks only new starts
					if (start_edge && !pd_s) begin
						state_r <= ACCP_CONV;
						bit_r <= ACCP_BIT_TOP;
						sar_r <= ACCP_RST_DATA;
					end
				end
				ACCP_CONV: begin
					sar_r[bit_r[3:0]] <= comp_i;
					if (bit_r == 5'h00) begin
						state_r <= ACCP_LOAD;
					end else begin
						bit_r <= bit_r - 5'h01;
					end
				end
				ACCP_LOAD: begin
					acq_r <= 8'h00;
					state_r <= lp_mode ? ACCP_ACQ : ACCP_IDLE;
				end
				ACCP_ACQ: begin
					if (acq_r >= ACCP_ACQ_LAST) begin
						if (!cnv_n_s && !pd_s) begin
							state_r <= ACCP_CONV;
							bit_r <= ACCP_BIT_TOP;
							sar_r <= ACCP_RST_DATA;
						end else begin
							state_r <= ACCP_IDLE;
						end
					end else begin
						acq_r <= acq_r + 8'h01;
						if (start_edge && !pd_s) begin
							state_r <= ACCP_CONV;
							bit_r <= ACCP_BIT_TOP;
							sar_r <= ACCP_RST_DATA;
						end
					end
				end
			endcase
		end
	end

	// result register and busy/hold flags
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || reset_s) begin
			shift_r <= ACCP_RST_DATA;
			busy_o <= 1'b0;
			hold_o <= 1'b0;
		end else begin
			if (state_r == ACCP_LOAD) begin
				shift_r <= sar_r;
			end
			// busy falls only once the result is in the shift register
			busy_o <= (state_r == ACCP_CONV) || (state_r == ACCP_LOAD) ||
				(state_r != ACCP_CONV && (start_edge ||
				(state_r == ACCP_ACQ && acq_r >= ACCP_ACQ_LAST &&
				!cnv_n_s)) && !pd_s);
			hold_o <= (state_r == ACCP_CONV);
		end
	end

	// output port
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			data_o <= ACCP_RST_DATA;
			data_oe_o <= 1'b0;
			data_hi_oe_o <= 4'hF;
			sclk_gated_o <= 1'b0;
		end else begin
			data_o <= shift_r;
			data_oe_o <= ~cs_n_s & ~rd_n_s;
			data_hi_oe_o <= 4'hF;
			sclk_gated_o <= sclk_s & ~cs_n_s;
		end
	end

	// serial_parallel_select only matters for the lower pins
	logic spsel_unused;
	assign spsel_unused = serial_parallel_select_i;

	property p_busy_reset;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		reset_s |=> !busy_o;
	endproperty
	a_busy_reset: assert property (p_busy_reset) else $error("busy in reset");

	property p_oe;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		data_oe_o |-> $past(!cs_n_s && !rd_n_s);
	endproperty
	a_oe: assert property (p_oe) else $error("bus on without cs and rd");

	property p_hi;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		##1 data_hi_oe_o == 4'hF;
	endproperty
	a_hi: assert property (p_hi) else $error("upper bits not driven");

	property p_pd;
		@(posedge clk_sys_i) disable iff (!rst_n_i || reset_s)
		(state_r == ACCP_IDLE && pd_s) |=> state_r == ACCP_IDLE;
	endproperty
	a_pd: assert property (p_pd) else $error("start under power-down");

	property p_start;
		@(posedge clk_sys_i) disable iff (!rst_n_i || reset_s)
		(state_r == ACCP_IDLE && start_edge && !pd_s) |=> ##1 hold_o;
	endproperty
	a_start: assert property (p_start) else $error("no hold on start");

	// run length of hold, checked at the cycle in which hold falls
	logic [4:0] hold_run_r;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || reset_s) begin
			hold_run_r <= 5'h00;
		end else if (hold_o) begin
			hold_run_r <= hold_run_r + 5'h01;
		end else begin
			hold_run_r <= 5'h00;
		end
	end

	property p_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i || reset_s)
		$fell(hold_o) |-> hold_run_r == 5'(ACCP_DATA_W);
	endproperty
	a_len: assert property (p_len) else $error("sar not 16 steps");

	property p_busy_load;
		@(posedge clk_sys_i) disable iff (!rst_n_i || reset_s)
		(state_r == ACCP_LOAD) |=> busy_o && shift_r == $past(sar_r);
	endproperty
	a_busy_load: assert property (p_busy_load) else $error("bad load");

	property p_abort;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		reset_s |=> state_r == ACCP_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("reset did not abort");

	property p_sclk;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		cs_n_s |=> !sclk_gated_o;
	endproperty
	a_sclk: assert property (p_sclk) else $error("sclk not gated");

	property p_restart;
		@(posedge clk_sys_i) disable iff (!rst_n_i || reset_s)
		(state_r == ACCP_ACQ && acq_r >= ACCP_ACQ_LAST && !cnv_n_s && !pd_s)
			|=> state_r == ACCP_CONV && busy_o;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
endmodule : accp_top
`default_nettype wire

// ==== dv/accp_host_model.sv ====
// host-side model answering comparator trials from a target code
`timescale 1ns/1ps
`default_nettype none
module accp_host_model (
	// clock and status
	input wire logic clk_sys_i,
	input wire logic hold_i,
	// target code
	input wire logic [15:0] code_i,
	// trial answer
	output logic comp_o
);
	logic [3:0] idx_r;
	// one trial per hold cycle, most significant first
	always_ff @(posedge clk_sys_i) begin
		idx_r <= hold_i ? idx_r - 4'h1 : 4'hF;
	end
	// hold rises one cycle after the first trial, so that trial sees bit 15
	assign comp_o = code_i[idx_r - {3'b000, hold_i}];
endmodule : accp_host_model
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the conversion control port
`timescale 1ns/1ps
`default_nettype none
module tb
	import accp_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cnv_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1, rst_pin = 1'b0;
	logic pd = 1'b0, sp_sel = 1'b0, sclk = 1'b0;
	logic lp = 1'b0, fast = 1'b0;
	logic comp, busy, hold, oe, sg;
	logic [15:0] data, code = 16'h0000;
	logic [3:0] hi_oe;
	logic [15:0] notes[$];
	int n_errors = 0, check_count = 0, seed = 32'hb0af_3a5b;
	always #20 clk_sys_i = ~clk_sys_i;
	accp_top accp_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.convert_start_n_i(cnv_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
		.reset_i(rst_pin), .power_down_request_i(pd),
		.low_power_sel_i(lp), .fast_sel_i(fast),
		.serial_parallel_select_i(sp_sel), .ext_sclk_i(sclk),
		.comp_i(comp), .busy_o(busy), .hold_o(hold), .data_o(data),
		.data_oe_o(oe), .data_hi_oe_o(hi_oe), .sclk_gated_o(sg));
	accp_host_model accp_host_model_inst (.clk_sys_i(clk_sys_i),
		.hold_i(hold), .code_i(code), .comp_o(comp));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic start(input logic [15:0] c, input int n = 3);
		code <= c;
		cnv_n <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
		cnv_n <= 1'b1;
	endtask : start
	// bounded wait, then room for the acquisition phase
	task automatic wait_fall;
		@(posedge clk_sys_i);
		chk({15'h0000, busy}, 16'h0001);
		for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk_sys_i);
		chk({15'h0000, busy}, 16'h0000);
		repeat (14) @(posedge clk_sys_i);
	endtask : wait_fall
	// result is on data from the edge at which busy drops; checked two edges later
	always @(negedge busy) begin
		@(posedge clk_sys_i);
		@(posedge clk_sys_i);
		if (notes.size() > 0) chk(data, notes.pop_front());
	end
	initial begin
		logic [15:0] c;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		chk(data, ACCP_RST_DATA);
		start(16'h5A5A);
		rst_pin <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		chk({15'h0000, busy}, 16'h0000);
		chk({15'h0000, hold}, 16'h0000);
		rst_pin <= 1'b0;
		repeat (14) @(posedge clk_sys_i);
		for (int i = 0; i < 6; i++) begin
			c = (i < 2) ? {16{i[0]}} : 16'($random(seed));
			sp_sel <= 1'($random(seed));
			notes.push_back(c);
			start(c);
			wait_fall();
			chk({12'h000, hi_oe}, 16'h000F);
		end
		for (int i = 0; i < 8; i++) begin
			{sclk, cs_n, rd_n} <= 3'(i);
			repeat (4) @(posedge clk_sys_i);
			chk({15'h0000, oe}, {15'h0000, ~cs_n & ~rd_n});
			chk({15'h0000, sg}, {15'h0000, sclk & ~cs_n});
		end
		// low-power mode: start held low restarts at the end of acquisition
		lp <= 1'b1;
		notes.push_back(16'h3C96);
		notes.push_back(16'h0F0F);
		code <= 16'h3C96;
		cnv_n <= 1'b0;
		repeat (22) @(posedge clk_sys_i);
		code <= 16'h0F0F;
		repeat (8) @(posedge clk_sys_i);
		cnv_n <= 1'b1;
		wait_fall();
		// both selects high is not low-power: no restart
		fast <= 1'b1;
		notes.push_back(16'hC33C);
		start(16'hC33C, 31);
		chk({15'h0000, busy}, 16'h0000);
		repeat (14) @(posedge clk_sys_i);
		{lp, fast} <= 2'b00;
		repeat (4) @(posedge clk_sys_i);
		notes.push_back(16'hA5C3);
		start(16'hA5C3);
		pd <= 1'b1;
		wait_fall();
		start(16'h1234);
		repeat (4) @(posedge clk_sys_i);
		chk({15'h0000, busy}, 16'h0000);
		chk(16'(notes.size()), 16'h0000);
		results();
	end
	initial begin
		#200000;
		n_errors++;
		results();
	end
endmodule : tb
`default_nettype wire
